//--- verilog/ocv_ctrl.sv
// on/off regulation, current limit, auto-restart and thermal control
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// [R01] enable or skip each cycle from feedback
// [R02] latch feedback 2.5 us after turn-off
// [R03] reduced current limit at light load
// [R04] low flyback feedback over 200 ms: restart
// [R05] restart off phase holds switch 2.5 s
// [R06] alternate phases until fault clears, then regulate
// [R07] low feedback current: open loop, 6 cycles
// [R08] over-temperature off, back on after cooling
// [R09] current limit ends the present pulse
// [R10] ignore current limit during turn-on blanking
// [R11] charge internal supply only while switch off
// [R12] jittered oscillator, delays counted in clocks

module ocv_ctrl #(
    parameter int AR_ON_CYC  = ocv_pkg::AR_ON_CYC,   // restart on-phase clocks
    parameter int AR_OFF_CYC = ocv_pkg::AR_OFF_CYC,  // restart off-phase clocks
    parameter int OL_CYCLES  = ocv_pkg::OL_CYCLES    // open-loop on-phase cycles
) (
    input  wire logic clk,              // 25 MHz oscillator clock
    input  wire logic rstn,             // supply-good reset, active low
    input  wire logic fb_above_th,      // sense pin above regulation threshold
    input  wire logic fb_low_fault,     // sense pin below threshold minus 0.3 V
    input  wire logic fb_cur_low,       // sense pin current below 120 uA
    input  wire logic ilim_trip,        // switch current above limit
    input  wire logic temp_hot,         // die above 142 C
    input  wire logic temp_cooled,      // die fallen 60 C below trip
    output logic      gate_en,          // power switch gate enable
    output logic      supply_charge_en, // internal supply charging enable
    output logic      ilim_reduced,     // reduced current-limit select
    output logic      open_loop,        // open loop flagged
    output logic      auto_restart,     // auto-restart in progress
    output logic      thermal_off       // thermal shutdown active
);

    // ------------------------------------------------------------------
    // sizes and checks
    // ------------------------------------------------------------------
    localparam int AR_MAX = (AR_ON_CYC > AR_OFF_CYC) ? AR_ON_CYC : AR_OFF_CYC;
    localparam int AR_W   = $clog2(AR_MAX + 1);
    localparam int ON_W   = $clog2(ocv_pkg::MAX_ON_CYC + 1);
    localparam int SP_W   = $clog2(ocv_pkg::SAMPLE_CYC + 1);
    localparam int OL_W   = $clog2(OL_CYCLES + 1);
    localparam int LL_W   = $clog2(ocv_pkg::LL_RUN + 1);

    generate
        if (AR_ON_CYC < 2 || AR_OFF_CYC < 2 || OL_CYCLES < 1) begin : g_chk_ar
            $error("ocv_ctrl: restart counts too small");
        end
        if (ocv_pkg::MAX_ON_CYC + ocv_pkg::SAMPLE_CYC + 2 >= ocv_pkg::OSC_BASE_CYC)
        begin : g_chk_cyc
            $error("ocv_ctrl: sample does not fit in the switching period");
        end
        if (ocv_pkg::BLANK_CYC >= ocv_pkg::MAX_ON_CYC) begin : g_chk_blank
            $error("ocv_ctrl: blanking longer than maximum on time");
        end
    endgenerate

    function automatic logic at_last(input logic [AR_W-1:0] cnt, input int lim);
        at_last = (cnt == AR_W'(lim - 1));
    endfunction

    // ------------------------------------------------------------------
    // oscillator
    // ------------------------------------------------------------------
    logic cyc_start;

    ocv_osc #(
        .BASE_CYC (ocv_pkg::OSC_BASE_CYC),
        .SPAN     (ocv_pkg::JIT_SPAN)
    ) u_osc (
        .clk       (clk),
        .rstn      (rstn),
        .cyc_start (cyc_start)
    );

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    ocv_pkg::ocv_state_t state_r;
    ocv_pkg::ocv_state_t state_nxt;

    logic            gate_r;
    logic            charge_r;
    logic [ON_W-1:0] on_cnt_r;

    logic            flyback_r;
    logic [SP_W-1:0] samp_cnt_r;
    logic            low_seen_r;
    logic            cur_low_seen_r;
    logic            fb_need_r;

    logic            fault_pend_r;
    logic            open_loop_r;
    logic [OL_W-1:0] ol_cnt_r;

    logic [AR_W-1:0] ar_cnt_r;
    logic [AR_W-1:0] ar_cnt_nxt;

    logic [LL_W-1:0] en_run_r;
    logic            light_r;
    logic            otp_r;

    // ------------------------------------------------------------------
    // switching cycle decode
    // ------------------------------------------------------------------
    wire in_off_w    = (state_r == ocv_pkg::ST_AR_OFF);
    wire run_ok_w    = !otp_r && !in_off_w;                               // [R05] [R08]
    wire start_w     = cyc_start && run_ok_w && fb_need_r && !gate_r;     // [R01]
    wire skip_w      = cyc_start && !start_w && !gate_r;

    // blanking and pulse end
    wire blank_done  = (on_cnt_r >= ON_W'(ocv_pkg::BLANK_CYC));            // [R10]
    wire ilim_hit_w  = gate_r && blank_done && ilim_trip;                  // [R09]
    wire max_hit_w   = gate_r && (on_cnt_r == ON_W'(ocv_pkg::MAX_ON_CYC - 1));
    wire turn_off_w  = gate_r && (ilim_hit_w || max_hit_w || !run_ok_w);
    wire gate_nxt    = start_w || (gate_r && !turn_off_w);
    wire gate_d_w    = gate_nxt && (state_nxt != ocv_pkg::ST_AR_OFF);     // [R05]

    // flyback sample and faults
    wire sample_w    = flyback_r && (samp_cnt_r == SP_W'(ocv_pkg::SAMPLE_CYC - 1)); // [R02]
    wire cyc_fault_w = low_seen_r || fb_low_fault;                         // [R04]
    wire ol_now_w    = cur_low_seen_r || fb_cur_low;                       // [R07]
    wire ol_trip_w   = turn_off_w && ol_now_w && (ol_cnt_r == OL_W'(OL_CYCLES - 1));

    // light load run
    wire ll_full_w   = (en_run_r == LL_W'(ocv_pkg::LL_RUN));

    // ------------------------------------------------------------------
    // restart state machine
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt  = state_r;
        ar_cnt_nxt = ar_cnt_r;
        case (state_r)
            ocv_pkg::ST_RUN: begin
                if (ol_trip_w || (fault_pend_r && at_last(ar_cnt_r, AR_ON_CYC))) begin // [R04] [R07]
                    state_nxt  = ocv_pkg::ST_AR_OFF;
                    ar_cnt_nxt = '0;
                end else if (fault_pend_r) begin
                    ar_cnt_nxt = ar_cnt_r + 1'b1;
                end else begin
                    ar_cnt_nxt = '0;
                end
            end

            ocv_pkg::ST_AR_OFF: begin
                if (at_last(ar_cnt_r, AR_OFF_CYC)) begin // [R05]
                    state_nxt  = ocv_pkg::ST_AR_ON;
                    ar_cnt_nxt = '0;
                end else begin
                    ar_cnt_nxt = ar_cnt_r + 1'b1;
                end
            end

            ocv_pkg::ST_AR_ON: begin
                if (ol_trip_w) begin // [R07]
                    state_nxt  = ocv_pkg::ST_AR_OFF;
                    ar_cnt_nxt = '0;
                end else if (sample_w && !cyc_fault_w && !open_loop_r) begin // [R06]
                    state_nxt  = ocv_pkg::ST_RUN;
                    ar_cnt_nxt = '0;
                end else if (at_last(ar_cnt_r, AR_ON_CYC)) begin // [R06]
                    state_nxt  = fault_pend_r ? ocv_pkg::ST_AR_OFF : ocv_pkg::ST_RUN;
                    ar_cnt_nxt = '0;
                end else begin
                    ar_cnt_nxt = ar_cnt_r + 1'b1;
                end
            end

            default: begin
                state_nxt  = ocv_pkg::ST_RUN;
                ar_cnt_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_r  <= ocv_pkg::ST_RUN;
            ar_cnt_r <= '0;
        end else begin
            state_r  <= state_nxt;
            ar_cnt_r <= ar_cnt_nxt;
        end
    end

    // ------------------------------------------------------------------
    // gate, blanking counter and supply charging
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            gate_r   <= 1'b0;
            on_cnt_r <= '0;
            charge_r <= ocv_pkg::RST_CHARGE;
        end else begin
            gate_r   <= gate_d_w;
            on_cnt_r <= gate_d_w ? (gate_r ? on_cnt_r + 1'b1 : '0) : '0;
            charge_r <= !gate_d_w; // [R11]
        end
    end

    // ------------------------------------------------------------------
    // flyback window and feedback sample
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            flyback_r  <= 1'b0;
            samp_cnt_r <= '0;
            low_seen_r <= 1'b0;
            fb_need_r  <= ocv_pkg::RST_FB_NEED;
        end else begin
            if (turn_off_w) begin // [R02]
                flyback_r  <= 1'b1;
                samp_cnt_r <= '0;
                low_seen_r <= 1'b0;
            end else if (sample_w) begin
                flyback_r  <= 1'b0;
                samp_cnt_r <= '0;
            end else if (flyback_r) begin
                samp_cnt_r <= samp_cnt_r + 1'b1;
                low_seen_r <= low_seen_r || fb_low_fault; // [R04]
            end

            if (in_off_w)
                fb_need_r <= 1'b1;
            else if (sample_w || skip_w)
                fb_need_r <= !fb_above_th; // [R01]
        end
    end

    // ------------------------------------------------------------------
    // fault and open-loop tracking
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            fault_pend_r   <= 1'b0;
            cur_low_seen_r <= 1'b0;
            open_loop_r    <= 1'b0;
            ol_cnt_r       <= '0;
        end else begin
            if (in_off_w && at_last(ar_cnt_r, AR_OFF_CYC))
                fault_pend_r <= 1'b0;
            else if (sample_w)
                fault_pend_r <= cyc_fault_w; // [R04]

            if (start_w)
                cur_low_seen_r <= 1'b0;
            else if (gate_r)
                cur_low_seen_r <= cur_low_seen_r || fb_cur_low;

            if (turn_off_w) begin // [R07]
                open_loop_r <= ol_now_w;
                ol_cnt_r    <= (ol_now_w && !ol_trip_w) ? ol_cnt_r + 1'b1 : '0;
            end else if (in_off_w) begin
                ol_cnt_r <= '0;
            end
        end
    end

    // ------------------------------------------------------------------
    // light load and thermal hysteresis
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            en_run_r <= '0;
            light_r  <= 1'b0;
            otp_r    <= 1'b0;
        end else begin
            if (start_w)
                en_run_r <= ll_full_w ? en_run_r : en_run_r + 1'b1;
            else if (skip_w)
                en_run_r <= '0;

            if (cyc_start)
                light_r <= !ll_full_w; // [R03]

            if (temp_hot)
                otp_r <= 1'b1; // [R08]
            else if (temp_cooled)
                otp_r <= 1'b0; // [R08]
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign gate_en          = gate_r;
    assign supply_charge_en = charge_r;
    assign ilim_reduced     = light_r;
    assign open_loop        = open_loop_r;
    assign auto_restart     = (state_r != ocv_pkg::ST_RUN);
    assign thermal_off      = otp_r;

endmodule

`default_nettype wire

//--- verilog/ocv_pkg.sv
// constants, timing and state codes for the on/off regulation controller
package ocv_pkg;

    // ------------------------------------------------------------------
    // clock
    // ------------------------------------------------------------------
    localparam int CLK_MHZ          = 25;

    // ------------------------------------------------------------------
    // times in their own units
    // ------------------------------------------------------------------
    localparam int SAMPLE_DELAY_NS  = 2500;
    localparam int BLANK_NS         = 200;
    localparam int OSC_PERIOD_NS    = 10000;
    localparam int MAX_ON_NS        = 6000;
    localparam int AR_ON_MS         = 200;
    localparam int AR_OFF_MS        = 2500;

    // ------------------------------------------------------------------
    // derived cycle counts
    // ------------------------------------------------------------------
    localparam int SAMPLE_CYC       = (SAMPLE_DELAY_NS * CLK_MHZ + 999) / 1000;
    localparam int BLANK_CYC        = (BLANK_NS * CLK_MHZ + 999) / 1000;
    localparam int OSC_BASE_CYC     = (OSC_PERIOD_NS * CLK_MHZ) / 1000;
    localparam int MAX_ON_CYC       = (MAX_ON_NS * CLK_MHZ) / 1000;
    localparam int AR_ON_CYC        = AR_ON_MS * CLK_MHZ * 1000;
    localparam int AR_OFF_CYC       = AR_OFF_MS * CLK_MHZ * 1000;

    // ------------------------------------------------------------------
    // other counts
    // ------------------------------------------------------------------
    localparam int OL_CYCLES        = 6;
    localparam int JIT_SPAN         = 16;
    localparam int LL_RUN           = 4;

    // ------------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------------
    localparam logic RST_FB_NEED    = 1'b1;
    localparam logic RST_CHARGE     = 1'b1;

    // ------------------------------------------------------------------
    // control states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RUN    = 3'h1,
        ST_AR_OFF = 3'h2,
        ST_AR_ON  = 3'h4
    } ocv_state_t;

endpackage

//--- verilog/ocv_osc.sv
// jittered switching-cycle oscillator
`timescale 1ns/1ps
`default_nettype none

module ocv_osc #(
    parameter int BASE_CYC = ocv_pkg::OSC_BASE_CYC,
    parameter int SPAN     = ocv_pkg::JIT_SPAN
) (
    input  wire logic clk,       // system clock
    input  wire logic rstn,      // sync reset, active low
    output logic      cyc_start  // one-cycle pulse at each cycle start
);

    localparam int W = $clog2(BASE_CYC + SPAN + 1);

    generate
        if (BASE_CYC < 2 || SPAN < 2 || SPAN >= BASE_CYC) begin : g_chk
            $error("ocv_osc: bad period or jitter span");
        end
    endgenerate

    // ------------------------------------------------------------------
    // period counter with triangular jitter offset
    // ------------------------------------------------------------------
    logic [W-1:0] cnt_r;
    logic [W-1:0] jit_r;
    logic         up_r;
    logic         start_r;

    wire  [W-1:0] last_w = W'(BASE_CYC - 1) + jit_r;
    wire          wrap_w = (cnt_r == last_w);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt_r   <= '0;
            jit_r   <= '0;
            up_r    <= 1'b1;
            start_r <= 1'b0;
        end else begin
            start_r <= wrap_w;
            cnt_r   <= wrap_w ? '0 : cnt_r + 1'b1;
            if (wrap_w) begin // [R12]
                jit_r <= up_r ? jit_r + 1'b1 : jit_r - 1'b1;
                if (up_r && jit_r == W'(SPAN - 2))
                    up_r <= 1'b0;
                else if (!up_r && jit_r == W'(1))
                    up_r <= 1'b1;
            end
        end
    end

    assign cyc_start = start_r;

endmodule

`default_nettype wire

//--- verilog/ocv_dummy_placeholder_none.sv
// intentionally empty compilation unit
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- test/ocv_ctrl_chk.sv
// port-level assertion checker for the regulation controller
`timescale 1ns/1ps
`default_nettype none

module ocv_ctrl_chk #(
    parameter int AR_ON_CYC  = 2000, // restart on-phase clocks
    parameter int AR_OFF_CYC = 3000, // restart off-phase clocks
    parameter int OL_CYCLES  = 6     // open-loop on-phase pulses
) (
    input wire logic clk,              // system clock
    input wire logic rstn,             // sync reset, active low
    input wire logic fb_above_th,      // sense above threshold
    input wire logic fb_low_fault,     // sense low fault
    input wire logic fb_cur_low,       // sense current low
    input wire logic ilim_trip,        // switch current over limit
    input wire logic temp_hot,         // die hot
    input wire logic temp_cooled,      // die cooled
    input wire logic gate_en,          // switch gate enable
    input wire logic supply_charge_en, // supply charge enable
    input wire logic ilim_reduced,     // reduced limit select
    input wire logic open_loop,        // open loop flag
    input wire logic auto_restart,     // restart in progress
    input wire logic thermal_off       // thermal shutdown
);
    // ------------------------------------------------------------------
    // helper counters
    // ------------------------------------------------------------------
    logic [7:0]  on_cnt_r;  // clocks the gate has been high
    logic [31:0] off_cnt_r; // clocks since restart began

    always_ff @(posedge clk) begin
        on_cnt_r <= (!rstn || !gate_en) ? 8'h00 : on_cnt_r + 8'h01;
    end

    always_ff @(posedge clk) begin
        off_cnt_r <= (!rstn || !auto_restart) ? 32'h0 : off_cnt_r + 32'h1;
    end

    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_on_hold;
        (gate_en || thermal_off || auto_restart) [*5];
    endsequence

    sequence s_hot_down;
        thermal_off ##1 !gate_en;
    endsequence

    a_charge_inverse: assert property (supply_charge_en == !gate_en)
        else $error("supply charge not inverse of gate");
    a_blank_hold: assert property ($rose(gate_en) |-> s_on_hold)
        else $error("pulse ended inside blanking");
    a_ilim_stop: assert property (gate_en && ilim_trip && on_cnt_r >= 8'h05 |=> !gate_en)
        else $error("current limit did not end pulse");
    a_max_on: assert property (gate_en |-> on_cnt_r < 8'h96)
        else $error("pulse longer than maximum on time");
    a_hot_off: assert property (temp_hot |=> s_hot_down)
        else $error("over-temperature did not stop switching");
    a_cool_on: assert property (thermal_off && temp_cooled && !temp_hot |=> !thermal_off)
        else $error("thermal shutdown not cleared after cooling");
    a_off_hold: assert property (auto_restart && off_cnt_r < 32'(AR_OFF_CYC - 1) |-> !gate_en)
        else $error("gate on during restart off phase");
    a_ol_turnoff: assert property ($rose(open_loop) |-> !gate_en)
        else $error("open loop flagged while switch on");
    a_restart_gate: assert property ($rose(auto_restart) |=> !gate_en [*8])
        else $error("gate on right after restart entry");

endmodule

bind ocv_ctrl ocv_ctrl_chk #(
    .AR_ON_CYC  (AR_ON_CYC),
    .AR_OFF_CYC (AR_OFF_CYC),
    .OL_CYCLES  (OL_CYCLES)
) u_chk (
    .clk(clk), .rstn(rstn), .fb_above_th(fb_above_th), .fb_low_fault(fb_low_fault),
    .fb_cur_low(fb_cur_low), .ilim_trip(ilim_trip), .temp_hot(temp_hot),
    .temp_cooled(temp_cooled), .gate_en(gate_en), .supply_charge_en(supply_charge_en),
    .ilim_reduced(ilim_reduced), .open_loop(open_loop), .auto_restart(auto_restart),
    .thermal_off(thermal_off)
);

`default_nettype wire

//--- test/ocv_plant.sv
// far-side model: switch current, winding sense and die temperature comparators
`timescale 1ns/1ps
`default_nettype none

module ocv_plant (
    input  wire logic       clk,          // system clock
    input  wire logic       gate_en,      // switch on
    input  wire logic [7:0] ilim_at,      // on clocks before current trips
    input  wire logic       fb_hi,        // output above regulation point
    input  wire logic       short_out,    // output shorted
    input  wire logic       open_div,     // top divider resistor missing
    input  wire logic       hot,          // die over trip point
    input  wire logic       cooled,       // die has cooled
    output logic            fb_above_th,  // sense above threshold
    output logic            fb_low_fault, // sense far below threshold
    output logic            fb_cur_low,   // sense current low
    output logic            ilim_trip,    // switch current over limit
    output logic            temp_hot,     // die hot flag
    output logic            temp_cooled   // die cooled flag
);
    logic [7:0] on_cnt_r; // clocks of conduction

    always_ff @(posedge clk) begin
        on_cnt_r <= gate_en ? on_cnt_r + 8'h01 : 8'h00;
    end

    // current ramps while the switch conducts
    assign ilim_trip    = gate_en && (on_cnt_r >= ilim_at);
    assign fb_above_th  = fb_hi && !short_out;
    // shorted output collapses the flyback level
    assign fb_low_fault = short_out && !gate_en;
    assign fb_cur_low   = open_div && gate_en;
    assign temp_hot     = hot;
    assign temp_cooled  = cooled && !hot;

endmodule

`default_nettype wire

//--- test/tb_top.sv
// self-checking bench for the regulation controller
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    localparam int AR_ON  = 2000;
    localparam int AR_OFF = 3000;

    logic       clk, rstn, fb_hi, short_out, open_div, hot, cooled;
    logic [7:0] ilim_at;
    logic       fb_above_th, fb_low_fault, fb_cur_low, ilim_trip, temp_hot, temp_cooled;
    logic       gate_en, supply_charge_en, ilim_reduced, open_loop, auto_restart, thermal_off;
    int         fail_count, num_checks, cyc, n, r;

    ocv_ctrl #(.AR_ON_CYC(AR_ON), .AR_OFF_CYC(AR_OFF), .OL_CYCLES(6)) dut (
        .clk(clk), .rstn(rstn), .fb_above_th(fb_above_th), .fb_low_fault(fb_low_fault),
        .fb_cur_low(fb_cur_low), .ilim_trip(ilim_trip), .temp_hot(temp_hot),
        .temp_cooled(temp_cooled), .gate_en(gate_en), .supply_charge_en(supply_charge_en),
        .ilim_reduced(ilim_reduced), .open_loop(open_loop), .auto_restart(auto_restart),
        .thermal_off(thermal_off));

    ocv_plant u_plant (
        .clk(clk), .gate_en(gate_en), .ilim_at(ilim_at), .fb_hi(fb_hi),
        .short_out(short_out), .open_div(open_div), .hot(hot), .cooled(cooled),
        .fb_above_th(fb_above_th), .fb_low_fault(fb_low_fault), .fb_cur_low(fb_cur_low),
        .ilim_trip(ilim_trip), .temp_hot(temp_hot), .temp_cooled(temp_cooled));

    // ------------------------------------------------------------------
    // clock and watchdog
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 40000) begin
            fail_count = fail_count + 1;
            test_done();
        end
    end

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #2;
    endtask

    // sel 0 waits on the gate, 1 on the restart flag
    task automatic wait_on(input int sel, input logic lvl, input int mx, output int c);
        c = 0;
        while (((sel == 0) ? gate_en : auto_restart) !== lvl && c < mx) begin
            tick(1);
            c++;
        end
    endtask

    task automatic count_rises(input int k, output int c);
        logic p;
        c = 0;
        repeat (k) begin
            p = gate_en;
            tick(1);
            if (gate_en === 1'b1 && p === 1'b0) c++;
        end
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        chk("gate_en", 0, gate_en);
        chk("supply_charge_en", 1, supply_charge_en);
        chk("ilim_reduced", 0, ilim_reduced);
        chk("open_loop", 0, open_loop);
        chk("auto_restart", 0, auto_restart);
        chk("thermal_off", 0, thermal_off);
    endtask

    task automatic t_regulate();
        fb_hi = 1'b0;
        ilim_at = 8'h14;
        wait_on(0, 1'b1, 300, n);
        chk("gate_rise", 1, gate_en);
        chk("charge_during_on", 0, supply_charge_en);
        wait_on(0, 1'b0, 200, n);
        chk("ilim_on_len", 21, n);
        chk("charge_after_off", 1, supply_charge_en);
        repeat (5) begin
            wait_on(0, 1'b1, 300, n);
            wait_on(0, 1'b0, 200, n);
        end
        chk("ilim_reduced_heavy", 0, ilim_reduced);
    endtask

    task automatic t_sample();
        fb_hi = 1'b0;
        for (int k = 0; k < 2; k++) begin
            wait_on(0, 1'b1, 300, n);
            wait_on(0, 1'b0, 200, n);
            tick(ocv_pkg::SAMPLE_CYC - 2 + k);
            fb_hi = 1'b1;
            tick(1);
            fb_hi = 1'b0;
            count_rises(200, r);
            chk("sample_rises", 1 - k, r);
        end
    endtask

    task automatic t_skip();
        fb_hi = 1'b1;
        tick(600);
        count_rises(600, r);
        chk("skip_rises", 0, r);
        chk("ilim_reduced_light", 1, ilim_reduced);
    endtask

    task automatic t_blank();
        fb_hi = 1'b0;
        ilim_at = 8'h00;
        wait_on(0, 1'b1, 600, n);
        wait_on(0, 1'b0, 200, n);
        chk("blank_on_len", ocv_pkg::BLANK_CYC + 1, n);
    endtask

    task automatic t_thermal();
        ilim_at = 8'h14;
        wait_on(0, 1'b1, 600, n);
        hot = 1'b1;
        tick(2);
        chk("thermal_set", 1, thermal_off);
        chk("thermal_gate", 0, gate_en);
        hot = 1'b0;
        count_rises(600, r);
        chk("thermal_rises", 0, r);
        cooled = 1'b1;
        tick(1);
        cooled = 1'b0;
        chk("thermal_clear", 0, thermal_off);
        wait_on(0, 1'b1, 300, n);
        chk("thermal_resume", 1, gate_en);
    endtask

    task automatic t_restart();
        short_out = 1'b1;
        wait_on(1, 1'b1, AR_ON + 1000, n);
        chk("ar_entry", 1, n >= AR_ON && n <= AR_ON + 600);
        wait_on(0, 1'b1, AR_OFF + 1000, n);
        chk("ar_off_len", 1, n >= AR_OFF - 10 && n <= AR_OFF + 600);
        chk("ar_on_phase", 1, auto_restart);
        tick(AR_ON + 600);
        count_rises(1000, r);
        chk("ar_reoff_rises", 0, r);
        wait_on(0, 1'b1, AR_OFF, n);
        short_out = 1'b0;
        wait_on(1, 1'b0, 1000, n);
        chk("ar_exit", 0, auto_restart);
    endtask

    task automatic t_open();
        logic p;
        wait_on(0, 1'b0, 300, n);
        open_div = 1'b1;
        r = 0;
        n = 0;
        while (auto_restart !== 1'b1 && n < 3000) begin
            p = gate_en;
            tick(1);
            n++;
            if (gate_en === 1'b1 && p === 1'b0) r++;
        end
        chk("ol_pulses", ocv_pkg::OL_CYCLES, r);
        chk("ol_flag", 1, open_loop);
        wait_on(0, 1'b1, AR_OFF + 1000, n);
        chk("ol_off_len", 1, n >= AR_OFF - 10);
        open_div = 1'b0;
        wait_on(1, 1'b0, 1000, n);
        chk("ol_exit", 0, auto_restart);
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        fail_count = 0;
        num_checks = 0;
        cyc = 0;
        rstn = 1'b0;
        fb_hi = 1'b0;
        short_out = 1'b0;
        open_div = 1'b0;
        hot = 1'b0;
        cooled = 1'b0;
        ilim_at = 8'hFF;
        tick(3);
        rstn = 1'b1;
        t_reset();
        t_regulate();
        t_sample();
        t_skip();
        t_blank();
        t_thermal();
        t_restart();
        t_open();
        test_done();
    end

endmodule

`default_nettype wire
